// ==== rtl/etrg_pkg.sv ====
/*
 * Package for the event triggered reset generator: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock.
 */
package etrg_pkg;

    localparam logic [7:0]  ETRG_OFS_G1_A     = 8'h38;
    localparam logic [7:0]  ETRG_OFS_G1_B     = 8'h39;
    localparam logic [7:0]  ETRG_OFS_G1_C     = 8'h3A;
    localparam logic [7:0]  ETRG_OFS_G2_A     = 8'h3B;
    localparam logic [7:0]  ETRG_OFS_G2_B     = 8'h3C;
    localparam logic [7:0]  ETRG_OFS_CFG      = 8'h3D;

    localparam logic [7:0]  ETRG_RST_VAL      = 8'h00;

    localparam int          ETRG_LEVEL_BIT    = 7;
    localparam int          ETRG_POL2_BIT     = 7;
    localparam int          ETRG_POL1_BIT     = 6;
    localparam int          ETRG_MERGE_BIT    = 5;
    localparam int          ETRG_HOLD_LSB     = 2;
    localparam int          ETRG_WIDTH_LSB    = 0;

    localparam int          ETRG_CLK_HZ       = 100_000_000;
    // hold time base: 0.5 s step, code n>0 gives (n+1) steps
    localparam int          ETRG_HOLD_STEP_MS = 500;
    localparam int          ETRG_HOLD_STEP_CYC = ETRG_CLK_HZ / 1000 * ETRG_HOLD_STEP_MS;
    localparam int          ETRG_PW0_US       = 500;
    localparam int          ETRG_PW1_US       = 1000;
    localparam int          ETRG_PW2_US       = 2000;
    localparam int          ETRG_PW3_US       = 10000;
    localparam int          ETRG_CYC_PER_US   = ETRG_CLK_HZ / 1_000_000;
    localparam int          ETRG_PW0_CYC      = ETRG_PW0_US * ETRG_CYC_PER_US;
    localparam int          ETRG_PW1_CYC      = ETRG_PW1_US * ETRG_CYC_PER_US;
    localparam int          ETRG_PW2_CYC      = ETRG_PW2_US * ETRG_CYC_PER_US;
    localparam int          ETRG_PW3_CYC      = ETRG_PW3_US * ETRG_CYC_PER_US;

    typedef struct packed {
        logic       level;
        logic [6:0] code;
    } etrg_slot_t;

    typedef struct packed {
        logic       second_output_polarity;
        logic       first_output_polarity;
        logic       external_reset_merge_enable;
        logic [2:0] hold_code;
        logic [1:0] width_code;
    } etrg_cfg_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } etrg_reg_req_t;

endpackage

// ==== rtl/etrg_top.sv ====
/*
 * Event triggered reset generator: two generators that fire a reset
 * pulse when all selected events are held together for the hold time.
 * Assumes register accesses arrive as one-cycle strobes from the serial
 * register interface on sys_clk, and that event status arrives as a
 * 128-entry vector of live states (key pressed / gpi or logic active)
 * from logic on the same clock. The external reset pin is asynchronous.
 */
// Operation
// - key slot: level 1 means press triggers
// - gpi/logic slot: level selects active or inactive
// - first generator has three seven-bit slots
// - second generator has two seven-bit slots
// - zero code slot is ignored
// - trigger only when all used slots match
// - second output polarity from config bit 7
// - first output polarity from config bit 6
// - merge enable ORs pin into first output
// - hold time immediate or 1.0-4.0 s
// - hold time shared, continuous activity needed
// - shared two-bit pulse width selection
`timescale 1ns/1ps
module etrg_top
    import etrg_pkg::*;
#(
    parameter int HOLD_STEP_CYC = ETRG_HOLD_STEP_CYC,
    parameter int PW0_CYC       = ETRG_PW0_CYC,
    parameter int PW1_CYC       = ETRG_PW1_CYC,
    parameter int PW2_CYC       = ETRG_PW2_CYC,
    parameter int PW3_CYC       = ETRG_PW3_CYC
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire etrg_reg_req_t reg_req,
    output logic [7:0]         reg_rdata,
    input  wire logic [127:0]  event_active,
    input  wire logic          ext_reset_pin,
    output logic               first_generated_reset_out,
    output logic               second_generated_reset_out
);

    etrg_slot_t first_gen_event_code_a_r, first_gen_event_code_b_r, first_gen_event_code_c_r;
    etrg_slot_t second_gen_event_code_a_r, second_gen_event_code_b_r;
    etrg_cfg_t  cfg_r;
    logic [7:0] reg_rdata_r;
    logic [7:0] rd_mux;

    // register writes and reads
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_gen_event_code_a_r  <= ETRG_RST_VAL;
            first_gen_event_code_b_r  <= ETRG_RST_VAL;
            first_gen_event_code_c_r  <= ETRG_RST_VAL;
            second_gen_event_code_a_r <= ETRG_RST_VAL;
            second_gen_event_code_b_r <= ETRG_RST_VAL;
            cfg_r                     <= ETRG_RST_VAL;
            reg_rdata_r               <= 8'h00;
        end else begin
            if (reg_req.we) begin
                case (reg_req.addr)
                    ETRG_OFS_G1_A: first_gen_event_code_a_r  <= reg_req.wdata;
                    ETRG_OFS_G1_B: first_gen_event_code_b_r  <= reg_req.wdata;
                    ETRG_OFS_G1_C: first_gen_event_code_c_r  <= reg_req.wdata;
                    ETRG_OFS_G2_A: second_gen_event_code_a_r <= reg_req.wdata;
                    ETRG_OFS_G2_B: second_gen_event_code_b_r <= reg_req.wdata;
                    ETRG_OFS_CFG:  cfg_r                     <= reg_req.wdata;
                    default: ;
                endcase
            end
            if (reg_req.re) begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

    assign rd_mux = (reg_req.addr == ETRG_OFS_G1_A) ? first_gen_event_code_a_r  :
                    (reg_req.addr == ETRG_OFS_G1_B) ? first_gen_event_code_b_r  :
                    (reg_req.addr == ETRG_OFS_G1_C) ? first_gen_event_code_c_r  :
                    (reg_req.addr == ETRG_OFS_G2_A) ? second_gen_event_code_a_r :
                    (reg_req.addr == ETRG_OFS_G2_B) ? second_gen_event_code_b_r :
                    (reg_req.addr == ETRG_OFS_CFG)  ? cfg_r : 8'h00;
    assign reg_rdata = reg_rdata_r;

    // slot match: keys and gpi/logic are handled alike, so level 0 on a key slot
    // simply compares against the released state, which counts as a hit and
    // can complete a combination; gpi/logic level 0 selects the inactive state
    function automatic logic slot_hit(input etrg_slot_t s, input logic [127:0] ev);
        slot_hit = (s.code == 7'h00) ? 1'b1 :
                   (ev[s.code] == s.level);
    endfunction

    function automatic logic any_used(input etrg_slot_t s);
        any_used = (s.code != 7'h00);
    endfunction

    wire g1_used  = any_used(first_gen_event_code_a_r) | any_used(first_gen_event_code_b_r)
                  | any_used(first_gen_event_code_c_r);
    wire g2_used  = any_used(second_gen_event_code_a_r) | any_used(second_gen_event_code_b_r);
    wire g1_combo = g1_used & slot_hit(first_gen_event_code_a_r, event_active)
                  & slot_hit(first_gen_event_code_b_r, event_active)
                  & slot_hit(first_gen_event_code_c_r, event_active);
    wire g2_combo = g2_used & slot_hit(second_gen_event_code_a_r, event_active)
                  & slot_hit(second_gen_event_code_b_r, event_active);

    // shared hold and width counts
    logic [31:0] hold_cyc;
    logic [31:0] width_cyc;
    assign hold_cyc  = (cfg_r.hold_code == 3'h0) ? 32'h0 :
                       32'(HOLD_STEP_CYC) * 32'({29'h0, cfg_r.hold_code} + 32'h1);
    assign width_cyc = (cfg_r.width_code == 2'h0) ? 32'(PW0_CYC) :
                       (cfg_r.width_code == 2'h1) ? 32'(PW1_CYC) :
                       (cfg_r.width_code == 2'h2) ? 32'(PW2_CYC) : 32'(PW3_CYC);

    logic g1_pulse, g2_pulse;

    etrg_gen u_gen1 (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .combo     (g1_combo),
        .hold_cyc  (hold_cyc),
        .width_cyc (width_cyc),
        .pulse     (g1_pulse)
    );

    etrg_gen u_gen2 (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .combo     (g2_combo),
        .hold_cyc  (hold_cyc),
        .width_cyc (width_cyc),
        .pulse     (g2_pulse)
    );

    // external pin passes three flops; change accepted when 2nd and 3rd agree
    logic [2:0] ext_sync_r;
    logic       ext_level_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_sync_r  <= 3'h0;
            ext_level_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_reset_pin};
            if (ext_sync_r[2] == ext_sync_r[1]) begin
                ext_level_r <= ext_sync_r[2];
            end
        end
    end

    wire g1_assert = g1_pulse | (cfg_r.external_reset_merge_enable & ext_level_r);
    wire g1_out    = g1_assert ~^ cfg_r.first_output_polarity;
    wire g2_out    = g2_pulse ~^ cfg_r.second_output_polarity;

    logic out1_r, out2_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out1_r <= 1'b1;
            out2_r <= 1'b1;
        end else begin
            out1_r <= g1_out;
            out2_r <= g2_out;
        end
    end
    assign first_generated_reset_out  = out1_r;
    assign second_generated_reset_out = out2_r;

endmodule

// one generator: hold qualify, single pulse, rearm on release
module etrg_gen
    import etrg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        combo,
    input  wire logic [31:0] hold_cyc,
    input  wire logic [31:0] width_cyc,
    output logic             pulse
);
    typedef enum logic [1:0] {ETRG_IDLE, ETRG_HOLD, ETRG_PULSE, ETRG_WAIT} etrg_state_t;

    etrg_state_t state_r;
    logic [31:0] cnt_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ETRG_IDLE;
            cnt_r   <= 32'h0;
        end else begin
            case (state_r)
                ETRG_IDLE: begin
                    cnt_r <= 32'h1;
                    if (combo && hold_cyc == 32'h0) begin
                        state_r <= ETRG_PULSE;
                    end else if (combo) begin
                        state_r <= ETRG_HOLD;
                    end
                end
                ETRG_HOLD: begin
                    if (!combo) begin
                        state_r <= ETRG_IDLE;
                    end else if (cnt_r >= hold_cyc) begin
                        state_r <= ETRG_PULSE;
                        cnt_r   <= 32'h1;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                ETRG_PULSE: begin
                    if (cnt_r >= width_cyc) begin
                        state_r <= ETRG_WAIT;
                    end
                    cnt_r <= cnt_r + 32'h1;
                end
                ETRG_WAIT: begin
                    if (!combo) begin
                        state_r <= ETRG_IDLE;
                    end
                end
                default: state_r <= ETRG_IDLE;
            endcase
        end
    end

    assign pulse = (state_r == ETRG_PULSE);
endmodule

// ==== verif/etrg_top_monitor.sv ====
/*
 * Port checker for etrg_top: shadows the registers, checks read data,
 * idle levels, pulse width, merge and rearm.
 * Assumes binding to etrg_top with the same width parameters.
 */
`timescale 1ns/1ps
module etrg_top_monitor
    import etrg_pkg::*;
#(
    parameter int PW0_CYC = ETRG_PW0_CYC,
    parameter int PW1_CYC = ETRG_PW1_CYC,
    parameter int PW2_CYC = ETRG_PW2_CYC,
    parameter int PW3_CYC = ETRG_PW3_CYC
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire etrg_reg_req_t reg_req,
    input wire logic [7:0]    reg_rdata,
    input wire logic [127:0]  event_active,
    input wire logic          ext_reset_pin,
    input wire logic          first_generated_reset_out,
    input wire logic          second_generated_reset_out
);
    logic [7:0]  sh_r [6];
    logic [7:0]  exp_r;
    logic [7:0]  cq_r;
    logic [15:0] cnt_r;
    etrg_cfg_t   cfg;
    assign cfg = etrg_cfg_t'(sh_r[5]);
    // event states go in as an argument so the continuous assigns see them change
    function automatic logic hit(input logic [7:0] s, input logic [127:0] ev);
        return (s[6:0] == 7'h00) || (ev[s[6:0]] == s[7]);
    endfunction
    wire mapped = (reg_req.addr[7:3] == 5'h07) && (reg_req.addr[2:0] < 3'h6);
    wire mrg    = cfg.external_reset_merge_enable;
    // polarity flips lag the config write by a cycle, so judge only a settled config;
    // the write cycle itself is out too, since the shadow takes the new polarity at once
    wire steady = (cq_r > 8'h04) && !(reg_req.we && reg_req.addr == ETRG_OFS_CFG);
    wire act1   = (first_generated_reset_out == cfg.first_output_polarity);
    wire act2   = (second_generated_reset_out == cfg.second_output_polarity);
    wire combo1 = hit(sh_r[0], event_active) && hit(sh_r[1], event_active)
        && hit(sh_r[2], event_active)
        && ((sh_r[0][6:0] | sh_r[1][6:0] | sh_r[2][6:0]) != 7'h00);
    wire combo2 = hit(sh_r[3], event_active) && hit(sh_r[4], event_active)
        && ((sh_r[3][6:0] | sh_r[4][6:0]) != 7'h00);
    wire [15:0] w_exp = 16'(cfg.width_code[1] ? (cfg.width_code[0] ? PW3_CYC : PW2_CYC)
        : (cfg.width_code[0] ? PW1_CYC : PW0_CYC));
    always_ff @(posedge sys_clk) begin
        exp_r <= mapped ? sh_r[reg_req.addr[2:0]] : 8'h00;
        if (rst) begin
            sh_r  <= '{default: 8'h00};
            cq_r  <= 8'h00;
            cnt_r <= 16'h0000;
        end else begin
            if (reg_req.we && mapped) sh_r[reg_req.addr[2:0]] <= reg_req.wdata;
            cq_r  <= (reg_req.we && reg_req.addr == ETRG_OFS_CFG) ? 8'h00
                : cq_r + 8'(cq_r != 8'hFF);
            cnt_r <= act1 ? cnt_r + 16'h0001 : 16'h0000;
        end
    end
    rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !reg_req.re |=> $stable(reg_rdata)) else $error("read data moved without a read");
    read_back_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_req.re && !reg_req.we |=> reg_rdata == exp_r) else $error("read data wrong");
    no_spur_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!combo1 && !mrg && steady)[*2] |=> !$rose(act1)) else $error("first fired alone");
    no_spur_two_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!combo2 && steady)[*2] |=> !$rose(act2)) else $error("second fired alone");
    merge_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ext_reset_pin && mrg && steady)[*6] |-> act1) else $error("pin not merged");
    pulse_width_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(act1) && !mrg && steady && ({8'h00, cq_r} > cnt_r) |-> cnt_r == w_exp)
        else $error("pulse width wrong");
    fire_now_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.hold_code == 3'h0 && $rose(combo1) && !act1 && steady |-> ##2 act1)
        else $error("immediate pulse late");
    rearm_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(act1) && combo1 && !mrg && steady |=> (!act1)[*8]) else $error("refired");
endmodule

bind etrg_top etrg_top_monitor #(
    .PW0_CYC(PW0_CYC), .PW1_CYC(PW1_CYC), .PW2_CYC(PW2_CYC), .PW3_CYC(PW3_CYC)
) mon_u (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .event_active(event_active), .ext_reset_pin(ext_reset_pin),
    .first_generated_reset_out(first_generated_reset_out),
    .second_generated_reset_out(second_generated_reset_out)
);

// ==== verif/etrg_pulse_rx.sv ====
/*
 * Receiver on one generated reset line: counts pulses, keeps last width.
 * Assumes the bench tells it the active level.
 */
`timescale 1ns/1ps
module etrg_pulse_rx (
    input  wire logic   sys_clk,
    input  wire logic   clr,
    input  wire logic   line,
    input  wire logic   pol,
    output logic        act,
    output logic [7:0]  pulse_cnt_r,
    output logic [15:0] width_r
);
    logic [15:0] run_r;
    assign act = (line == pol);
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            run_r       <= 16'h0000;
            pulse_cnt_r <= 8'h00;
            width_r     <= 16'h0000;
        end else begin
            run_r <= act ? run_r + 16'h0001 : 16'h0000;
            if (act && run_r == 16'h0000) pulse_cnt_r <= pulse_cnt_r + 8'h01;
            if (!act && run_r != 16'h0000) width_r <= run_r;
        end
    end
endmodule

// ==== verif/tb_etrg_top.sv ====
/*
 * Bench for etrg_top: registers, pulses, hold time, polarity, merge.
 * Assumes shortened hold step and width parameters set below.
 */
`timescale 1ns/1ps
module tb_etrg_top
    import etrg_pkg::*;
;
    int            pw [4] = '{4, 8, 16, 80};
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    logic          clr = 1'b1;
    logic          p1 = 1'b0;
    logic          p2 = 1'b0;
    logic          ext_reset_pin = 1'b0;
    etrg_reg_req_t reg_req = '0;
    logic [127:0]  event_active = '0;
    logic [7:0]    reg_rdata, c1, c2;
    logic [15:0]   w1, w2;
    logic          o1, o2, a1, a2;
    int            err_count = 0;
    int            checked = 0;
    int            n;
    always #5 sys_clk = ~sys_clk;
    etrg_top #(.HOLD_STEP_CYC(10), .PW0_CYC(4), .PW1_CYC(8), .PW2_CYC(16), .PW3_CYC(80)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .event_active(event_active), .ext_reset_pin(ext_reset_pin),
        .first_generated_reset_out(o1), .second_generated_reset_out(o2));
    etrg_pulse_rx rx1_u (.sys_clk(sys_clk), .clr(clr), .line(o1), .pol(p1), .act(a1),
        .pulse_cnt_r(c1), .width_r(w1));
    etrg_pulse_rx rx2_u (.sys_clk(sys_clk), .clr(clr), .line(o2), .pol(p2), .act(a2),
        .pulse_cnt_r(c2), .width_r(w2));
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req <= '{1'b1, 1'b0, a, d};
        cyc(1);
        reg_req.we <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        cyc(1);
        reg_req.re <= 1'b0;
        cyc(1);
        chk(24'(reg_rdata), 24'(e));
    endtask
    // the receivers see a polarity flip as a pulse, so clear them once it settles
    task automatic setcfg(input logic [7:0] v);
        wr(ETRG_OFS_CFG, v);
        p1 <= v[ETRG_POL1_BIT];
        p2 <= v[ETRG_POL2_BIT];
        cyc(3);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(20000);
        err_count++;
        close_out;
    end
    initial begin
        cyc(2);
        rst <= 1'b0;
        clr <= 1'b0;
        cyc(1);
        chk(24'({o1, o2}), 24'h3);
        for (int i = 0; i < 6; i++) wr(8'h38 + 8'(i), (i < 5) ? 8'h91 + 8'(i) : 8'h1E);
        for (int i = 0; i < 7; i++)
            rd(8'h38 + 8'(i), (i < 5) ? 8'h91 + 8'(i) : (i == 5) ? 8'h1E : 8'h00);
        for (int i = 0; i < 5; i++) wr(8'h38 + 8'(i), 8'h00);
        $display("test registers done");
        wr(ETRG_OFS_G1_A, 8'h85);
        wr(ETRG_OFS_G1_B, 8'h86);
        for (int w = 0; w < 4; w++) begin
            setcfg(8'(w));
            event_active[5] <= 1'b1;
            cyc(20);
            chk(24'(c1), 24'h0);
            event_active[6] <= 1'b1;
            cyc(120);
            chk({c1, w1}, {8'h01, 16'(pw[w])});
            event_active[6:5] <= 2'b00;
            cyc(4);
            event_active[6:5] <= 2'b11;
            cyc(100);
            chk(24'(c1), 24'h2);
            event_active[6:5] <= 2'b00;
            cyc(2);
        end
        $display("test first generator done");
        setcfg(8'h80);
        chk(24'({o1, o2}), 24'h2);
        wr(ETRG_OFS_G2_A, 8'h0A);
        cyc(20);
        chk({c2, w2}, {8'h01, 16'h0004});
        wr(ETRG_OFS_G2_B, 8'h8B);
        event_active[10] <= 1'b1;
        cyc(4);
        event_active[10] <= 1'b0;
        cyc(20);
        chk(24'(c2), 24'h1);
        event_active[11] <= 1'b1;
        cyc(20);
        chk(24'(c2), 24'h2);
        wr(ETRG_OFS_G2_A, 8'h00);
        wr(ETRG_OFS_G2_B, 8'h00);
        $display("test second generator done");
        for (int h = 1; h < 8; h += 6) begin
            setcfg(8'h40 | 8'(h << 2));
            event_active[6:5] <= 2'b11;
            cyc(h * 5);
            event_active[5] <= 1'b0;
            cyc(2);
            event_active[5] <= 1'b1;
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
            end while (!a1 && n < 500);
            chk(24'(n >= (h + 1) * 10 && n <= (h + 1) * 10 + 4), 24'h1);
            // the receiver counts the pulse only at the next rising edge
            @(negedge sys_clk);
            chk(24'({c1, o1}), 24'h3);
            @(posedge sys_clk);
            event_active[6:5] <= 2'b00;
            cyc(100);
        end
        $display("test hold time done");
        setcfg(8'h20);
        ext_reset_pin <= 1'b1;
        cyc(10);
        chk(24'({o1, o2}), 24'h1);
        setcfg(8'h00);
        cyc(10);
        chk(24'({o1, o2}), 24'h3);
        ext_reset_pin <= 1'b0;
        $display("test merge done");
        close_out;
    end
endmodule
